//--- gfr_global_fault_recorder.sv
// global fault classification, recording and termination
`timescale 1ns/10ps
module gfr_global_fault_recorder #(
  parameter bit GLOBAL_STALL_SUPPORTED    = 1'b1,
  parameter bit NS_STALL_DIS_APPLIES_TO_S = 1'b0,
  parameter bit S_STALL_DIS_APPLIES_TO_NS = 1'b0,
  parameter bit NS_STALL_EN_APPLIES_TO_S  = 1'b0,
  parameter int SID_W                     = 16,
  parameter int ADDR_W                    = 64
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // transaction presented after stream matching
  input  wire logic              i_txn_valid,
  input  wire logic              i_txn_secure,
  input  wire logic              i_txn_write,
  input  wire logic              i_txn_ifetch,
  input  wire logic              i_txn_exit_nonsecure,
  input  wire logic [SID_W-1:0]  i_txn_stream_id,
  input  wire logic [ADDR_W-1:0] i_txn_addr,
  input  wire logic              i_txn_unsupported,
  input  wire logic              i_txn_has_bank,
  input  wire logic              i_match_none,
  input  wire logic              i_match_multi,
  input  wire logic [1:0]        i_stream_to_context_entry_type,
  input  wire logic              i_first_impl,
  input  wire logic              i_first_secure,
  input  wire logic [1:0]        i_first_type,
  input  wire logic              i_first_type_supported,
  input  wire logic              i_first_wide_regime_flag,
  input  wire logic              i_second_impl,
  input  wire logic              i_second_secure,
  input  wire logic [1:0]        i_second_type,
  input  wire logic              i_second_wide_regime_flag,
  // context fault from translation
  input  wire logic              i_ctx_fault,
  input  wire logic              i_ctx_fault_in_second,
  input  wire logic              i_ctx_irq_missing,
  input  wire logic              i_ctx_stall_fault,
  input  wire logic              i_ctx_bank_secure,
  input  wire logic              i_first_context_abort_report_enable,
  input  wire logic              i_second_context_abort_report_enable,
  input  wire logic [31:0]       i_context_fault_status,
  // configuration access and external abort events
  input  wire logic              i_cfg_fault,
  input  wire logic              i_cfg_secure,
  input  wire logic              i_cfg_write,
  input  wire logic [ADDR_W-1:0] i_cfg_addr,
  input  wire logic              i_ext_fault,
  input  wire logic              i_ext_secure,
  // control bits
  input  wire logic              i_ns_global_stall_enable,
  input  wire logic              i_s_global_stall_enable,
  input  wire logic              i_ns_stall_disable,
  input  wire logic              i_s_stall_disable,
  input  wire logic              i_ns_unknown_stream_fault_cfg,
  input  wire logic              i_s_unknown_stream_fault_cfg,
  input  wire logic              i_ns_match_conflict_fault_cfg,
  input  wire logic              i_s_match_conflict_fault_cfg,
  input  wire logic              i_config_fault_report_enable,
  input  wire logic              i_external_fault_override,
  input  wire logic              i_secure_ifetch_check,
  input  wire logic              i_stall_release,
  input  wire logic              i_ns_status_clear,
  input  wire logic              i_s_status_clear,
  // outputs
  output logic                   o_ns_global_stall_enable,
  output logic                   o_s_global_stall_enable,
  output logic                   o_stall,
  output logic                   o_txn_terminate,
  output logic                   o_txn_abort,
  output logic                   o_txn_raz_wi,
  output logic                   o_ctx_fault_present,
  output logic                   o_ctx_permission_fault,
  output logic [31:0]            o_ns_global_fault_status,
  output logic [31:0]            o_ns_global_fault_syndrome_first,
  output logic [31:0]            o_ns_global_fault_syndrome_second,
  output logic [ADDR_W-1:0]      o_ns_global_fault_address,
  output logic [31:0]            o_s_global_fault_status,
  output logic [31:0]            o_s_global_fault_syndrome_first,
  output logic [31:0]            o_s_global_fault_syndrome_second,
  output logic [ADDR_W-1:0]      o_s_global_fault_address
);

  // ==========================================
  // stall enable read-back
  logic ns_stall_dis_eff;
  logic s_stall_dis_eff;
  logic ns_stall_en_eff;
  logic s_stall_en_eff;

  always_comb begin
    ns_stall_dis_eff = i_ns_stall_disable | (S_STALL_DIS_APPLIES_TO_NS & i_s_stall_disable);
    s_stall_dis_eff  = i_s_stall_disable | (NS_STALL_DIS_APPLIES_TO_S & i_ns_stall_disable);
    ns_stall_en_eff  = GLOBAL_STALL_SUPPORTED & ~ns_stall_dis_eff & i_ns_global_stall_enable;
    s_stall_en_eff   = GLOBAL_STALL_SUPPORTED & ~s_stall_dis_eff & i_s_global_stall_enable;
  end

  assign o_ns_global_stall_enable = ns_stall_en_eff;
  assign o_s_global_stall_enable  = s_stall_en_eff;

  // ==========================================
  // global stall state
  logic stall_active;
  logic next_stall_active;
  logic stall_trigger;
  logic stall_en_for_bank;

  always_comb begin
    // secure banks follow their own enable, optionally the non-secure one too
    stall_en_for_bank = i_ctx_bank_secure ? (s_stall_en_eff | (NS_STALL_EN_APPLIES_TO_S & ns_stall_en_eff))
                                          : ns_stall_en_eff;
    stall_trigger     = i_ctx_stall_fault & stall_en_for_bank;
    next_stall_active = stall_active;
    if (i_stall_release) begin
      next_stall_active = 1'b0;
    end
    if (stall_trigger) begin
      next_stall_active = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      stall_active <= 1'b0;
    end else begin
      stall_active <= next_stall_active;
    end
  end

  // held until released; no per-bank resume is tracked here
  // later arrivals wait whatever context they map to
  assign o_stall = stall_active & i_txn_valid;

  // ==========================================
  // context bank validity checks
  logic usf_cfg;
  logic smcf_cfg;
  logic icf_first;
  logic icf_nested;
  logic ucbf_first;
  logic ucbf_nested;
  logic perm_fault;
  logic [gfr_pkg::GFS_W-1:0] txn_cause;
  logic                      txn_nested;

  always_comb begin
    usf_cfg  = i_txn_secure ? i_s_unknown_stream_fault_cfg : i_ns_unknown_stream_fault_cfg;
    smcf_cfg = i_txn_secure ? i_s_match_conflict_fault_cfg : i_ns_match_conflict_fault_cfg;
    ucbf_first = ~i_first_impl | (i_first_secure != i_txn_secure);
    icf_first  = (i_stream_to_context_entry_type == gfr_pkg::S2C_TYPE_FAULT) |
                 ~i_first_type_supported |
                 (i_first_type == gfr_pkg::CB_TYPE_S1_FAULT) |
                 (i_first_secure & (i_first_type != gfr_pkg::CB_TYPE_S1_BYP));
    ucbf_nested = (i_first_type == gfr_pkg::CB_TYPE_NESTED) & ~i_second_impl;
    icf_nested  = (i_first_type == gfr_pkg::CB_TYPE_NESTED) & i_second_impl &
                  (i_second_secure | (i_second_type != gfr_pkg::CB_TYPE_S2_ONLY) |
                   (i_first_wide_regime_flag & ~i_second_wide_regime_flag));
    perm_fault = i_secure_ifetch_check & i_txn_secure & i_txn_ifetch & i_txn_exit_nonsecure;
    txn_cause  = '0;
    txn_nested = 1'b0;
    // first hit in check order wins
    if (i_match_multi & smcf_cfg) begin
      txn_cause[gfr_pkg::GFS_SMCF] = 1'b1;
    end else if (i_match_none & usf_cfg) begin
      txn_cause[gfr_pkg::GFS_USF] = 1'b1;
    end else if (i_match_none | i_match_multi) begin
      txn_cause = '0;
    end else if (i_stream_to_context_entry_type == gfr_pkg::S2C_TYPE_FAULT) begin
      txn_cause[gfr_pkg::GFS_ICF] = 1'b1;
    end else if (ucbf_first) begin
      txn_cause[gfr_pkg::GFS_UCBF] = 1'b1;
    end else if (icf_first) begin
      txn_cause[gfr_pkg::GFS_ICF] = 1'b1;
      txn_nested = 1'b1;
    end else if (ucbf_nested) begin
      txn_cause[gfr_pkg::GFS_UCBF] = 1'b1;
      txn_nested = 1'b1;
    end else if (icf_nested) begin
      txn_cause[gfr_pkg::GFS_ICF] = 1'b1;
      txn_nested = 1'b1;
    end else if (i_ctx_fault & i_ctx_irq_missing) begin
      txn_cause[gfr_pkg::GFS_UCIF] = 1'b1;
      txn_nested = i_ctx_fault_in_second;
    end else if (perm_fault & ~i_txn_has_bank) begin
      txn_cause[gfr_pkg::GFS_PF] = 1'b1;
    end else if (i_txn_unsupported) begin
      txn_cause[gfr_pkg::GFS_UUT] = 1'b1;
    end
    if (!i_txn_valid) begin
      txn_cause  = '0;
      txn_nested = 1'b0;
    end
  end

  // ==========================================
  // termination and abort
  logic txn_gfault;

  always_comb begin
    txn_gfault          = |txn_cause;
    o_txn_terminate     = txn_gfault | (i_txn_valid & i_ctx_fault);
    o_txn_raz_wi        = txn_gfault;
    o_ctx_permission_fault = i_txn_valid & perm_fault & i_txn_has_bank;
    o_ctx_fault_present = |(i_context_fault_status & ~gfr_pkg::CFS_FORMAT_MASK);
    if (txn_cause[gfr_pkg::GFS_UUT]) begin
      o_txn_abort = i_config_fault_report_enable;
    end else if (txn_gfault) begin
      o_txn_abort = 1'b1;
    end else if (i_txn_valid & i_ctx_fault) begin
      o_txn_abort = i_ctx_fault_in_second ? i_second_context_abort_report_enable
                                          : i_first_context_abort_report_enable;
    end else begin
      o_txn_abort = 1'b0;
    end
  end

  // ==========================================
  // status helpers
  // full details only go into a bank with nothing recorded, multi included
  function automatic logic status_is_clear(input logic [31:0] st);
    return st == gfr_pkg::GFS_RESET;
  endfunction

  // a busy bank keeps every field and only gains the multiple-fault flag
  function automatic logic [31:0] mark_multi(input logic [31:0] st);
    logic [31:0] res;
    res = st;
    res[gfr_pkg::GFS_MULTI_POS] = 1'b1;
    return res;
  endfunction

  // ==========================================
  // banked recording
  logic [31:0]       gfs      [2];
  logic [31:0]       syn0     [2];
  logic [31:0]       syn1     [2];
  logic [ADDR_W-1:0] gfa      [2];
  logic [31:0]       next_gfs [2];
  logic [31:0]       next_syn0[2];
  logic [31:0]       next_syn1[2];
  logic [ADDR_W-1:0] next_gfa [2];

  // one event per bank per cycle; transaction, then config, then external
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      next_gfs[b]  = gfs[b];
      next_syn0[b] = syn0[b];
      next_syn1[b] = syn1[b];
      next_gfa[b]  = gfa[b];
      if ((b == 0) ? i_ns_status_clear : i_s_status_clear) begin
        next_gfs[b] = gfr_pkg::GFS_RESET;
      end
      if (txn_gfault && (int'(i_txn_secure) == b)) begin
        if (status_is_clear(gfs[b])) begin
          next_gfs[b]  = {23'h000000, txn_cause};
          next_syn0[b] = '0;
          next_syn0[b][gfr_pkg::SYN_NESTED_POS] = txn_nested;
          next_syn0[b][gfr_pkg::SYN_NS_POS]     = ~i_txn_secure;
          next_syn0[b][gfr_pkg::SYN_WR_POS]     = i_txn_write;
          next_syn0[b][gfr_pkg::SYN_IND_POS]    = i_txn_ifetch;
          next_syn1[b] = 32'(i_txn_stream_id);
          next_gfa[b]  = i_txn_addr;
        end else begin
          next_gfs[b] = mark_multi(gfs[b]);
        end
      end else if (i_cfg_fault && (int'(i_cfg_secure) == b)) begin
        if (status_is_clear(gfs[b])) begin
          next_gfs[b] = '0;
          next_gfs[b][gfr_pkg::GFS_CAF] = 1'b1;
          next_syn0[b] = '0; // nested captured as zero
          next_syn0[b][gfr_pkg::SYN_WR_POS] = i_cfg_write;
          next_gfa[b] = i_cfg_addr;
        end else begin
          next_gfs[b] = mark_multi(gfs[b]);
        end
      end else if (i_ext_fault && (int'(i_ext_secure) == b)) begin
        if (status_is_clear(gfs[b])) begin
          next_gfs[b] = '0;
          next_gfs[b][gfr_pkg::GFS_EF] = 1'b1; // only status moves
        end else begin
          next_gfs[b] = mark_multi(gfs[b]);
        end
      end
    end
  end

  // external override has no say in what gets recorded here
  logic unused_override;
  assign unused_override = i_external_fault_override;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int b = 0; b < 2; b++) begin
        gfs[b]  <= gfr_pkg::GFS_RESET;
        syn0[b] <= gfr_pkg::SYN_RESET;
        syn1[b] <= gfr_pkg::SYN_RESET;
        gfa[b]  <= ADDR_W'(gfr_pkg::ADDR_RESET);
      end
    end else begin
      for (int b = 0; b < 2; b++) begin
        gfs[b]  <= next_gfs[b];
        syn0[b] <= next_syn0[b];
        syn1[b] <= next_syn1[b];
        gfa[b]  <= next_gfa[b];
      end
    end
  end

  assign o_ns_global_fault_status          = gfs[0];
  assign o_ns_global_fault_syndrome_first  = syn0[0];
  assign o_ns_global_fault_syndrome_second = syn1[0];
  assign o_ns_global_fault_address         = gfa[0];
  assign o_s_global_fault_status           = gfs[1];
  assign o_s_global_fault_syndrome_first   = syn0[1];
  assign o_s_global_fault_syndrome_second  = syn1[1];
  assign o_s_global_fault_address          = gfa[1];

endmodule

//--- gfr_pkg.sv
// package of constants for the global fault recorder
package gfr_pkg;
  // ==========================================
  // stream-to-context types
  localparam logic [1:0] S2C_TYPE_FAULT   = 2'h2;
  // context bank types
  localparam logic [1:0] CB_TYPE_S2_ONLY  = 2'h0;
  localparam logic [1:0] CB_TYPE_S1_BYP   = 2'h1;
  localparam logic [1:0] CB_TYPE_S1_FAULT = 2'h2;
  localparam logic [1:0] CB_TYPE_NESTED   = 2'h3;
  // ==========================================
  // global fault status field positions
  localparam int GFS_W         = 9;
  localparam int GFS_ICF       = 0;
  localparam int GFS_USF       = 1;
  localparam int GFS_SMCF      = 2;
  localparam int GFS_UCBF      = 3;
  localparam int GFS_UCIF      = 4;
  localparam int GFS_CAF       = 5;
  localparam int GFS_EF        = 6;
  localparam int GFS_PF        = 7;
  localparam int GFS_UUT       = 8;
  localparam int GFS_MULTI_POS = 31;
  localparam logic [31:0] GFS_RESET = 32'h0000_0000;
  // syndrome field positions
  localparam int SYN_NESTED_POS = 0;
  localparam int SYN_NS_POS     = 1;
  localparam int SYN_WR_POS     = 2;
  localparam int SYN_IND_POS    = 3;
  localparam int SYN_STREAM_LSB = 16;
  localparam logic [31:0] SYN_RESET  = 32'h0000_0000;
  localparam logic [63:0] ADDR_RESET = 64'h0;
  // context fault status format field, ignored by the fault test
  localparam logic [31:0] CFS_FORMAT_MASK = 32'h0000_0600;
endpackage

//--- gfr_monitor.sv
// assertion checker for the global fault recorder
`timescale 1ns/10ps
module gfr_monitor #(
  parameter int ADDR_W = 64
) (
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_txn_valid,
  input wire logic              i_txn_secure,
  input wire logic              i_txn_write,
  input wire logic              i_txn_ifetch,
  input wire logic [ADDR_W-1:0] i_txn_addr,
  input wire logic              i_match_none,
  input wire logic              i_match_multi,
  input wire logic              i_cfg_fault,
  input wire logic              i_cfg_secure,
  input wire logic [ADDR_W-1:0] i_cfg_addr,
  input wire logic              i_ext_fault,
  input wire logic              i_ext_secure,
  input wire logic              i_ctx_stall_fault,
  input wire logic              i_ctx_bank_secure,
  input wire logic              i_ns_global_stall_enable,
  input wire logic              i_ns_stall_disable,
  input wire logic              i_ns_unknown_stream_fault_cfg,
  input wire logic              i_ns_match_conflict_fault_cfg,
  input wire logic              i_ns_status_clear,
  input wire logic              o_ns_global_stall_enable,
  input wire logic              o_stall,
  input wire logic              o_txn_terminate,
  input wire logic              o_txn_raz_wi,
  input wire logic [31:0]       o_ns_global_fault_status,
  input wire logic [31:0]       o_ns_global_fault_syndrome_first,
  input wire logic [ADDR_W-1:0] o_ns_global_fault_address
);
  // ==========================================
  // helpers
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic ns_usf;
  logic st_zero;
  assign ns_usf = i_txn_valid && !i_txn_secure && i_match_none && !i_match_multi && i_ns_unknown_stream_fault_cfg;
  assign st_zero = (o_ns_global_fault_status == 32'h0);
  // ==========================================
  // assertions
  usf_term_a: assert property (ns_usf |-> o_txn_terminate && o_txn_raz_wi)
    else $error("unknown stream not terminated");
  conflict_term_a: assert property (i_txn_valid && !i_txn_secure && i_match_multi
    && i_ns_match_conflict_fault_cfg |-> o_txn_terminate) else $error("conflict not terminated");
  first_capture_a: assert property (ns_usf && st_zero |=> o_ns_global_fault_status == 32'h2
    && o_ns_global_fault_address == $past(i_txn_addr)
    && o_ns_global_fault_syndrome_first[3:0] == {$past(i_txn_ifetch), $past(i_txn_write), 2'b10})
    else $error("first fault not captured");
  multi_only_a: assert property (ns_usf && !st_zero && !i_ns_status_clear |=> o_ns_global_fault_status[31]
    && o_ns_global_fault_status[30:0] == $past(o_ns_global_fault_status[30:0])
    && $stable(o_ns_global_fault_address)) else $error("later fault changed record");
  cfg_capture_a: assert property (i_cfg_fault && !i_cfg_secure && !i_txn_valid && st_zero
    |=> o_ns_global_fault_status == 32'h20 && o_ns_global_fault_address == $past(i_cfg_addr)
    && !o_ns_global_fault_syndrome_first[0]) else $error("config fault capture wrong");
  ext_only_a: assert property (i_ext_fault && !i_ext_secure && !i_txn_valid && !i_cfg_fault
    && st_zero |=> o_ns_global_fault_status == 32'h40 && $stable(o_ns_global_fault_address))
    else $error("external fault capture wrong");
  stall_read_a: assert property (o_ns_global_stall_enable
    == (i_ns_global_stall_enable && !i_ns_stall_disable)) else $error("stall enable readback wrong");
  stall_hold_a: assert property (i_ctx_stall_fault && !i_ctx_bank_secure && o_ns_global_stall_enable
    ##1 i_txn_valid |-> o_stall) else $error("stall not applied");
  cover property (ns_usf && !st_zero);
  cover property (i_cfg_fault && st_zero);
  cover property (o_stall);
endmodule
bind gfr_global_fault_recorder gfr_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

//--- gfr_initiator.sv
// upstream initiator model presenting transactions
`timescale 1ns/10ps
module gfr_initiator (
  input  wire logic   i_clk_sys,
  output logic        o_txn_valid,
  output logic        o_txn_secure,
  output logic        o_txn_write,
  output logic        o_txn_ifetch,
  output logic [15:0] o_txn_stream_id,
  output logic [63:0] o_txn_addr,
  output logic        o_match_none,
  output logic        o_match_multi
);
  initial begin
    {o_txn_valid, o_txn_secure, o_txn_write, o_txn_ifetch, o_match_none, o_match_multi} = 6'h0;
    o_txn_stream_id = 16'h0;
    o_txn_addr = 64'h0;
  end
  task automatic present(input logic sec, wr, fetch, input logic [15:0] sid,
                         input logic [63:0] addr, input logic none, multi);
    @(posedge i_clk_sys);
    o_txn_valid <= 1'b1;
    {o_txn_secure, o_txn_write, o_txn_ifetch, o_match_none, o_match_multi} <= {sec, wr, fetch, none, multi};
    o_txn_stream_id <= sid;
    o_txn_addr <= addr;
  endtask
  // valid drops and released stream id and address show the inverse; the other transaction lines keep their last value
  task automatic idle();
    @(posedge i_clk_sys);
    o_txn_valid <= 1'b0;
    o_txn_stream_id <= ~o_txn_stream_id;
    o_txn_addr <= ~o_txn_addr;
  endtask
endmodule

//--- global_fault_recorder_bench.sv
// self-checking bench for the global fault recorder
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module global_fault_recorder_bench;
  // ==========================================
  // signals
  logic i_clk_sys, i_resetn = 1'b0, i_txn_valid, i_txn_secure, i_txn_write, i_txn_ifetch, i_match_none;
  logic i_match_multi, i_txn_exit_nonsecure = 1'b0, i_txn_unsupported = 1'b0, i_txn_has_bank = 1'b1;
  logic [15:0] i_txn_stream_id;
  logic [63:0] i_txn_addr, i_cfg_addr = 64'h0, o_ns_global_fault_address, o_s_global_fault_address;
  logic [1:0] i_stream_to_context_entry_type = 2'h0, i_first_type = 2'h1, i_second_type = 2'h0, sel;
  logic i_first_impl = 1'b1, i_first_secure = 1'b0, i_first_type_supported = 1'b1, i_first_wide_regime_flag = 1'b0;
  logic i_second_impl = 1'b1, i_second_secure = 1'b0, i_second_wide_regime_flag = 1'b0, i_ctx_fault = 1'b0;
  logic i_ctx_fault_in_second = 1'b0, i_ctx_irq_missing = 1'b0, i_ctx_stall_fault = 1'b0, i_ctx_bank_secure = 1'b0;
  logic i_first_context_abort_report_enable = 1'b0, i_second_context_abort_report_enable = 1'b0;
  logic [31:0] i_context_fault_status = 32'h0;
  logic i_cfg_fault = 1'b0, i_cfg_secure = 1'b0, i_cfg_write = 1'b0, i_ext_fault = 1'b0, i_ext_secure = 1'b0;
  logic i_ns_global_stall_enable = 1'b0, i_s_global_stall_enable = 1'b0, i_ns_stall_disable = 1'b0;
  logic i_s_stall_disable = 1'b0, i_ns_unknown_stream_fault_cfg = 1'b1, i_s_unknown_stream_fault_cfg = 1'b1;
  logic i_ns_match_conflict_fault_cfg = 1'b1, i_s_match_conflict_fault_cfg = 1'b1, i_secure_ifetch_check = 1'b0;
  logic i_config_fault_report_enable = 1'b1, i_external_fault_override = 1'b0, i_stall_release = 1'b0;
  logic i_ns_status_clear = 1'b0, i_s_status_clear = 1'b0, o_ns_global_stall_enable, o_s_global_stall_enable;
  logic o_stall, o_txn_terminate, o_txn_abort, o_txn_raz_wi, o_ctx_fault_present, o_ctx_permission_fault;
  logic [31:0] o_ns_global_fault_status, o_ns_global_fault_syndrome_first, o_ns_global_fault_syndrome_second;
  logic [31:0] o_s_global_fault_status, o_s_global_fault_syndrome_first, o_s_global_fault_syndrome_second;
  logic [31:0] exp_st [11] = '{32'h1, 32'h1, 32'h8, 32'h8, 32'h1, 32'h1, 32'h10, 32'h80, 32'h100, 32'h4, 32'h2};
  logic sec;
  logic [31:0] st_sel;
  logic [31:0] st_oth;
  assign st_sel = sec ? o_s_global_fault_status : o_ns_global_fault_status;
  assign st_oth = sec ? o_ns_global_fault_status : o_s_global_fault_status;
  int n_fail = 0;
  int cmp_count = 0;
  gfr_global_fault_recorder u_dut (.*);
  gfr_initiator u_init (
    .i_clk_sys       (i_clk_sys),
    .o_txn_valid     (i_txn_valid),
    .o_txn_secure    (i_txn_secure),
    .o_txn_write     (i_txn_write),
    .o_txn_ifetch    (i_txn_ifetch),
    .o_txn_stream_id (i_txn_stream_id),
    .o_txn_addr      (i_txn_addr),
    .o_match_none    (i_match_none),
    .o_match_multi   (i_match_multi)
  );
  // ==========================================
  // tasks
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic clear_all();
    @(posedge i_clk_sys);
    {i_ns_status_clear, i_s_status_clear} <= 2'h3;
    @(posedge i_clk_sys);
    {i_ns_status_clear, i_s_status_clear} <= 2'h0;
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_fail++;
    end_sim();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    u_init.present(1'b0, 1'b1, 1'b1, 16'h1234, 64'hcafe_0010, 1'b1, 1'b0);
    #1 `CHK("terminate", 1'b1, o_txn_terminate)
    `CHK("raz_wi", 1'b1, o_txn_raz_wi)
    u_init.present(1'b0, 1'b0, 1'b0, 16'h0055, 64'hbeef_0020, 1'b1, 1'b0);
    #1 `CHK("status", 32'h2, o_ns_global_fault_status)
    `CHK("address", 64'hcafe_0010, o_ns_global_fault_address)
    `CHK("syndrome", 4'he, o_ns_global_fault_syndrome_first[3:0])
    `CHK("stream", 16'h1234, o_ns_global_fault_syndrome_second[15:0])
    u_init.idle();
    #1 `CHK("multi", 32'h8000_0002, o_ns_global_fault_status)
    `CHK("held address", 64'hcafe_0010, o_ns_global_fault_address)
    clear_all();
    i_ns_unknown_stream_fault_cfg <= 1'b0;
    u_init.present(1'b0, 1'b0, 1'b0, 16'h1, 64'h40, 1'b1, 1'b0);
    #1 `CHK("no fault", 1'b0, o_txn_terminate)
    u_init.present(1'b0, 1'b0, 1'b0, 16'h2, 64'h48, 1'b0, 1'b1);
    u_init.idle();
    #1 `CHK("conflict", 32'h4, o_ns_global_fault_status)
    clear_all();
    {i_cfg_fault, i_cfg_write, i_cfg_addr} <= {2'h3, 64'hff8};
    @(posedge i_clk_sys);
    i_cfg_fault <= 1'b0;
    #1 `CHK("cfg status", 32'h20, o_ns_global_fault_status)
    `CHK("cfg address", 64'hff8, o_ns_global_fault_address)
    `CHK("cfg nested", 1'b0, o_ns_global_fault_syndrome_first[0])
    clear_all();
    i_ext_fault <= 1'b1;
    @(posedge i_clk_sys);
    i_ext_fault <= 1'b0;
    #1 `CHK("ext status", 32'h40, o_ns_global_fault_status)
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk_sys);
      {i_ns_global_stall_enable, i_ns_stall_disable, i_s_global_stall_enable, i_s_stall_disable} <= {2{2'(k)}};
      #1 `CHK("ns enable", k == 2, o_ns_global_stall_enable)
      `CHK("s enable", k == 2, o_s_global_stall_enable)
    end
    @(posedge i_clk_sys);
    {i_ns_global_stall_enable, i_ns_stall_disable, i_ctx_stall_fault} <= 3'h5;
    u_init.present(1'b1, 1'b0, 1'b0, 16'h3, 64'h50, 1'b0, 1'b0);
    i_ctx_stall_fault <= 1'b0;
    #1 `CHK("stall", 1'b1, o_stall)
    u_init.idle();
    i_stall_release <= 1'b1;
    @(posedge i_clk_sys);
    i_stall_release <= 1'b0;
    u_init.present(1'b0, 1'b0, 1'b0, 16'h4, 64'h58, 1'b0, 1'b0);
    #1 `CHK("released", 1'b0, o_stall)
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk_sys);
      sel = 2'(k);
      {i_ctx_fault, i_ctx_fault_in_second, i_first_context_abort_report_enable} <= {1'b1, sel};
      i_second_context_abort_report_enable <= !sel[0];
      u_init.present(1'b0, 1'b0, 1'b0, 16'h7, 64'h80, 1'b0, 1'b0);
      #1 `CHK("context abort", sel[1] ? !sel[0] : sel[0], o_txn_abort)
    end
    u_init.idle();
    i_context_fault_status <= 32'h600;
    {i_txn_exit_nonsecure, i_secure_ifetch_check, i_first_secure} <= 3'h7;
    #1 `CHK("format only", 1'b0, o_ctx_fault_present)
    u_init.present(1'b1, 1'b0, 1'b1, 16'h9, 64'h90, 1'b0, 1'b0);
    #1 `CHK("bank permission", 1'b1, o_ctx_permission_fault)
    `CHK("bank fault only", 1'b0, o_txn_raz_wi)
    u_init.idle();
    clear_all();
    for (int k = 0; k < 11; k++) begin
      sec = (k == 7) || (k > 8);
      i_stream_to_context_entry_type <= (k == 0) ? 2'h2 : 2'h0;
      i_first_type <= (k == 1) ? 2'h2 : (k > 2 && k < 6) ? 2'h3 : 2'h1;
      {i_first_impl, i_second_impl, i_first_wide_regime_flag} <= {k != 2, k != 3, k == 5};
      i_second_type <= (k == 4) ? 2'h1 : 2'h0;
      {i_ctx_fault, i_ctx_irq_missing, i_first_secure} <= {k == 6, k == 6, sec};
      {i_txn_exit_nonsecure, i_secure_ifetch_check, i_txn_has_bank} <= {k == 7, k == 7, k != 7};
      {i_txn_unsupported, i_external_fault_override, i_context_fault_status} <= {k == 8, k == 8, 32'h601};
      u_init.present(sec, 1'b0, k == 7, 16'(k), 64'h1000 + 64'(k), k == 10, k == 9);
      #1 `CHK("fault terminate", 1'b1, o_txn_terminate)
      if (k == 8) `CHK("unsupported abort", 1'b1, o_txn_abort)
      if (k == 8) `CHK("fault present", 1'b1, o_ctx_fault_present)
      u_init.idle();
      #1 `CHK("bank status", exp_st[k], st_sel)
      `CHK("other bank", 32'h0, st_oth)
      if (k == 2 || k == 3) `CHK("nested bit", k == 3, o_ns_global_fault_syndrome_first[0])
      clear_all();
    end
    #1 `CHK("s address", 64'h100a, o_s_global_fault_address)
    `CHK("s syndromes", 64'ha, {o_s_global_fault_syndrome_first, o_s_global_fault_syndrome_second})
    end_sim();
  end
endmodule
